// *** include/gfm_defs.svh ***
`ifndef GFM_DEFS_SVH
`define GFM_DEFS_SVH
`define GFM_ADDR_PIN0 16'h0300
`define GFM_ADDR_PIN1 16'h0301
`define GFM_ADDR_PIN2 16'h0302
`define GFM_ADDR_PIN3 16'h0303
`define GFM_FUNC_LSB 0
`define GFM_FUNC_MSB 3
`define GFM_DIR_BIT 4
`define GFM_RST_FUNC1 4'h6
`define GFM_RST_FUNC2 4'hA
`define GFM_RST_FUNC3 4'h3
`define GFM_RST_DIR1 1'h0
`define GFM_RST_DIR2 1'h1
`define GFM_RST_DIR3 1'h1
`define GFM_GROUP_BASE 4'h9
`define GFM_NUM_GROUPS 7
`define GFM_SYNC_STAGES 2
`endif

// *** include/gfm_pkg.sv ***
package gfm_pkg;
    typedef logic [3:0] gfm_func_t;
    // status sources feeding the pins, one bit each
    typedef enum logic [3:0] {
        GFM_SRC_IRQ = 4'h0,
        GFM_SRC_REF0_VALID = 4'h1,
        GFM_SRC_REF1_VALID = 4'h2,
        GFM_SRC_DBG_SYS_FB = 4'h3,
        GFM_SRC_DLOOP0_HOLD = 4'h4,
        GFM_SRC_DLOOP1_HOLD = 4'h5,
        GFM_SRC_DLOOP0_LOCK = 4'h6,
        GFM_SRC_DLOOP1_LOCK = 4'h7,
        GFM_SRC_ALOOP0_LOCK = 4'h8,
        GFM_SRC_ALOOP1_LOCK = 4'h9,
        GFM_SRC_ALOOP2_LOCK = 4'hA,
        GFM_SRC_RF_LOCK = 4'hB,
        GFM_SRC_READY = 4'hC,
        GFM_SRC_DLOOP0_SEL = 4'hD,
        GFM_SRC_DLOOP1_SEL = 4'hE
    } gfm_src_t;
    localparam int GFM_NUM_SRC = 15;
    // what one pin does for a given function code
    typedef enum logic [2:0] {
        GFM_ROLE_STATUS = 3'h0,
        GFM_ROLE_DISQ0 = 3'h1,
        GFM_ROLE_DISQ1 = 3'h2,
        GFM_ROLE_GROUP = 3'h3,
        GFM_ROLE_NONE = 3'h4
    } gfm_role_t;
endpackage

// *** rtl/gfm_mux.sv ***
`timescale 1ns/100ps
`include "gfm_defs.svh"
module gfm_mux #(
    parameter int NUM_PINS = 3,
    parameter int NUM_GROUPS = `GFM_NUM_GROUPS
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // byte-wide register port, one-cycle write and read strobes
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // high while a nonvolatile configuration load is writing registers
    input wire logic nv_load,
    // status sources
    input wire logic irq,
    input wire logic ref0_valid,
    input wire logic ref1_valid,
    input wire logic dbg_sys_fb_clk,
    input wire logic dloop0_hold,
    input wire logic dloop1_hold,
    input wire logic dloop0_lock,
    input wire logic dloop1_lock,
    input wire logic aloop0_lock,
    input wire logic aloop1_lock,
    input wire logic aloop2_lock,
    input wire logic rf_lock,
    input wire logic device_ready_status_bit,
    input wire logic dloop0_sel,
    input wire logic dloop1_sel,
    // pins 1 to 3, bit 0 is pin 1
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    // control results
    output logic ref0_disqualify,
    output logic ref1_disqualify,
    output logic [NUM_GROUPS-1:0] group_enable
);
    initial begin
        if (NUM_PINS != 3 || NUM_GROUPS != `GFM_NUM_GROUPS) begin
            $error("gfm_mux serves exactly three pins and seven groups");
        end
    end

    logic [3:0] func [NUM_PINS];
    logic [3:0] next_func [NUM_PINS];
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] next_dir;
    logic [NUM_PINS-1:0] pin_sync;
    logic [gfm_pkg::GFM_NUM_SRC-1:0] src_vec;
    gfm_pkg::gfm_role_t role [NUM_PINS];
    gfm_pkg::gfm_src_t src [NUM_PINS];
    logic [2:0] grp [NUM_PINS];
    logic [NUM_PINS-1:0] next_pin_out;
    logic [NUM_PINS-1:0] next_pin_oe;
    logic next_disq0;
    logic next_disq1;
    logic [NUM_GROUPS-1:0] next_group_en;
    logic [7:0] next_rdata;
    logic next_rvalid;

    function automatic logic [1:0] pin_of_addr(input logic [15:0] a);
        pin_of_addr = 2'(a - `GFM_ADDR_PIN1);
    endfunction

    function automatic logic addr_hits(input logic [15:0] a);
        addr_hits = (a >= `GFM_ADDR_PIN1) && (a <= `GFM_ADDR_PIN3);
    endfunction

    assign src_vec = {dloop1_sel, dloop0_sel, device_ready_status_bit, rf_lock,
                      aloop2_lock, aloop1_lock, aloop0_lock, dloop1_lock,
                      dloop0_lock, dloop1_hold, dloop0_hold, dbg_sys_fb_clk,
                      ref1_valid, ref0_valid, irq};

    // control levels come from outside, so they are synchronised first
    gfm_sync #(.WIDTH(NUM_PINS)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_dec
            gfm_pin_decode #(.PIN(gi + 1)) u_dec (
                .func(func[gi]),
                .role(role[gi]),
                .src(src[gi]),
                .group(grp[gi])
            );
        end
    endgenerate

    // register writes; a configuration load never touches these fields
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            next_func[i] = func[i];
        end
        next_dir = dir;
        next_rdata = reg_rdata;
        next_rvalid = 1'b0;
        if (reg_wr && !nv_load && addr_hits(reg_addr)) begin
            next_func[pin_of_addr(reg_addr)] = reg_wdata[`GFM_FUNC_MSB:`GFM_FUNC_LSB];
            // pin 3 has no direction bit in its register
            if (pin_of_addr(reg_addr) != 2'h2) begin
                next_dir[pin_of_addr(reg_addr)] = reg_wdata[`GFM_DIR_BIT];
            end
        end
        if (reg_rd) begin
            next_rvalid = 1'b1;
            next_rdata = 8'h00;
            if (addr_hits(reg_addr)) begin
                next_rdata[`GFM_FUNC_MSB:`GFM_FUNC_LSB] = func[pin_of_addr(reg_addr)];
                if (pin_of_addr(reg_addr) != 2'h2) begin
                    next_rdata[`GFM_DIR_BIT] = dir[pin_of_addr(reg_addr)];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            func[0] <= `GFM_RST_FUNC1;
            func[1] <= `GFM_RST_FUNC2;
            func[2] <= `GFM_RST_FUNC3;
            dir <= {`GFM_RST_DIR3, `GFM_RST_DIR2, `GFM_RST_DIR1};
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                func[i] <= next_func[i];
            end
            dir <= next_dir;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // pin routing, registered so each pin changes cleanly one cycle after its write
    always_comb begin
        next_pin_out = '0;
        next_pin_oe = '0;
        next_disq0 = 1'b0;
        next_disq1 = 1'b0;
        next_group_en = '1;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (role[i] == gfm_pkg::GFM_ROLE_STATUS) begin
                next_pin_out[i] = src_vec[src[i]];
                next_pin_oe[i] = dir[i];
            end else if (role[i] == gfm_pkg::GFM_ROLE_DISQ0) begin
                next_disq0 = next_disq0 | pin_sync[i];
            end else if (role[i] == gfm_pkg::GFM_ROLE_DISQ1) begin
                next_disq1 = next_disq1 | pin_sync[i];
            end else if (role[i] == gfm_pkg::GFM_ROLE_GROUP) begin
                // a low pin holds its group off; unclaimed groups stay enabled
                next_group_en[grp[i]] = next_group_en[grp[i]] & pin_sync[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe <= '0;
            ref0_disqualify <= 1'b0;
            ref1_disqualify <= 1'b0;
            group_enable <= '1;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            ref0_disqualify <= next_disq0;
            ref1_disqualify <= next_disq1;
            group_enable <= next_group_en;
        end
    end

    a_write_applies: assert property (@(posedge ref_clk) disable iff (!rst_b)
        reg_wr && !nv_load && reg_addr == `GFM_ADDR_PIN2 ##1 1'b1 |->
        func[1] == $past(reg_wdata[3:0]))
        else $error("pin 2 field did not take the written code");

    a_load_keeps: assert property (@(posedge ref_clk) disable iff (!rst_b)
        nv_load |=> func[0] == $past(func[0]) && func[2] == $past(func[2]))
        else $error("configuration load changed a function field");

    a_ready_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[2] == 4'h3 |=> pin_out[2] == $past(device_ready_status_bit))
        else $error("pin 3 does not show device ready");

    // only pin 1 decodes a disqualify role, so no other pin can feed this output
    a_disq_input: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[0] == 4'h7 |->
        ##3 (ref0_disqualify == $past(pin_in[0], 3) || $past(func[0]) != 4'h7))
        else $error("pin 1 disqualify does not follow the pin");

    a_group_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[1] == 4'h9 && func[0] != 4'h9 && func[2] != 4'h9
        |=> group_enable[0] == $past(pin_sync[1]))
        else $error("group 0 enable does not follow pin 2");

    a_read_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
        reg_rd && reg_addr == `GFM_ADDR_PIN1 |=>
        reg_rvalid && reg_rdata[3:0] == $past(func[0]))
        else $error("pin 1 field read back wrong");

    a_others_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
        reg_wr && reg_addr == `GFM_ADDR_PIN2 |=>
        $stable(func[0]) && $stable(func[2]))
        else $error("pin 2 write disturbed another field");

    a_status_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        role[0] == gfm_pkg::GFM_ROLE_STATUS && dir[0] |=> pin_oe[0])
        else $error("pin 1 status output not driven");

    a_holdover_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[1] == 4'h2 |=> pin_out[1] == $past(dloop0_hold))
        else $error("pin 2 does not show holdover");

    a_rf_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[0] == 4'h5 |=> pin_out[0] == $past(rf_lock))
        else $error("pin 1 does not show rf lock");

    a_sel_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[2] == 4'h8 |=> pin_out[2] == $past(dloop1_sel))
        else $error("pin 3 does not show input selection");

    a_control_undriven: assert property (@(posedge ref_clk) disable iff (!rst_b)
        func[1] >= 4'h9 |=> !pin_oe[1])
        else $error("pin 2 driven while used as input");

    c_write_pin1: cover property (@(posedge ref_clk) disable iff (!rst_b)
        reg_wr && reg_addr == `GFM_ADDR_PIN1);
    c_disq1: cover property (@(posedge ref_clk) disable iff (!rst_b) ref1_disqualify);
    c_disq0: cover property (@(posedge ref_clk) disable iff (!rst_b) ref0_disqualify);
    c_group_off: cover property (@(posedge ref_clk) disable iff (!rst_b)
        !group_enable[1]);
    c_load_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
        nv_load && reg_wr);
endmodule

// *** rtl/gfm_pin_decode.sv ***
`timescale 1ns/100ps
`include "gfm_defs.svh"
module gfm_pin_decode #(
    parameter int PIN = 1
) (
    input wire logic [3:0] func,
    output gfm_pkg::gfm_role_t role,
    output gfm_pkg::gfm_src_t src,
    output logic [2:0] group
);
    initial begin
        if (PIN < 1 || PIN > 3) begin
            $error("gfm_pin_decode serves pins 1 to 3 only");
        end
    end

    always_comb begin
        role = gfm_pkg::GFM_ROLE_STATUS;
        src = gfm_pkg::GFM_SRC_IRQ;
        group = 3'h0;
        if (func >= `GFM_GROUP_BASE) begin
            role = gfm_pkg::GFM_ROLE_GROUP;
            group = 3'(func - `GFM_GROUP_BASE);
        end else if (PIN == 1) begin
            unique case (func)
                4'h0: src = gfm_pkg::GFM_SRC_IRQ;
                4'h1: src = gfm_pkg::GFM_SRC_REF1_VALID;
                4'h2: src = gfm_pkg::GFM_SRC_DBG_SYS_FB;
                4'h3: src = gfm_pkg::GFM_SRC_DLOOP1_LOCK;
                4'h4: src = gfm_pkg::GFM_SRC_ALOOP1_LOCK;
                4'h5: src = gfm_pkg::GFM_SRC_RF_LOCK;
                4'h6: src = gfm_pkg::GFM_SRC_DLOOP1_SEL;
                4'h7: role = gfm_pkg::GFM_ROLE_DISQ0;
                4'h8: role = gfm_pkg::GFM_ROLE_DISQ1;
                default: role = gfm_pkg::GFM_ROLE_NONE;
            endcase
        end else if (PIN == 2) begin
            unique case (func)
                4'h0: src = gfm_pkg::GFM_SRC_IRQ;
                4'h1: src = gfm_pkg::GFM_SRC_REF0_VALID;
                4'h2: src = gfm_pkg::GFM_SRC_DLOOP0_HOLD;
                4'h3: src = gfm_pkg::GFM_SRC_DLOOP1_HOLD;
                4'h4: src = gfm_pkg::GFM_SRC_DLOOP1_LOCK;
                4'h5: src = gfm_pkg::GFM_SRC_DLOOP1_LOCK;
                4'h6: src = gfm_pkg::GFM_SRC_ALOOP0_LOCK;
                4'h7: src = gfm_pkg::GFM_SRC_RF_LOCK;
                4'h8: src = gfm_pkg::GFM_SRC_DLOOP0_SEL;
                default: role = gfm_pkg::GFM_ROLE_NONE;
            endcase
        end else begin
            unique case (func)
                4'h0: src = gfm_pkg::GFM_SRC_IRQ;
                4'h1: src = gfm_pkg::GFM_SRC_REF0_VALID;
                4'h2: src = gfm_pkg::GFM_SRC_REF1_VALID;
                4'h3: src = gfm_pkg::GFM_SRC_READY;
                4'h4: src = gfm_pkg::GFM_SRC_DLOOP0_LOCK;
                4'h5: src = gfm_pkg::GFM_SRC_DLOOP1_LOCK;
                4'h6: src = gfm_pkg::GFM_SRC_ALOOP0_LOCK;
                4'h7: src = gfm_pkg::GFM_SRC_ALOOP2_LOCK;
                4'h8: src = gfm_pkg::GFM_SRC_DLOOP1_SEL;
                default: role = gfm_pkg::GFM_ROLE_NONE;
            endcase
        end
    end
endmodule

// *** rtl/gfm_sync.sv ***
`timescale 1ns/100ps
`include "gfm_defs.svh"
module gfm_sync #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage is read only by the second stage
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    initial begin
        if (WIDTH < 1) begin
            $error("gfm_sync width must be at least one");
        end
    end

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// *** tb/gfm_board.sv ***
`timescale 1ns/100ps
module gfm_board (
    input wire logic ref_clk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] brd_val,
    input wire logic [2:0] brd_en,
    output logic [2:0] pin_in
);
    logic [2:0] float_pat = 3'h5;
    // a pin nobody drives wanders, so a floating level never reads as a clean value
    always @(posedge ref_clk) begin
        float_pat <= ~float_pat;
    end
    // the device wins while it drives; the board drives only a released pin
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (brd_en[i] ? brd_val[i] : float_pat[i]);
        end
    end
endmodule

// *** tb/gfm_mux_tb.sv ***
`timescale 1ns/100ps
module gfm_mux_tb;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nv_load = 1'b0;
    logic [14:0] srcv = 15'h1000;
    logic [2:0] brd_val = 3'h0;
    logic [2:0] brd_en = 3'h1;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [2:0] pin_in;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic ref0_dq;
    logic ref1_dq;
    logic [6:0] group_en;
    int failures = 0;
    int cmp_count = 0;
    // pin nibble, code nibble, source index in package order
    localparam logic [11:0] ROUTE [25] = '{12'h100, 12'h112, 12'h123, 12'h137, 12'h149,
        12'h15B, 12'h16E, 12'h200, 12'h211, 12'h224, 12'h235, 12'h247, 12'h257, 12'h268,
        12'h27B,
        12'h28D, 12'h300, 12'h311, 12'h322, 12'h33C, 12'h346, 12'h357, 12'h368, 12'h37A,
        12'h38E};

    always #25 ref_clk = ~ref_clk;

    gfm_mux i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .nv_load(nv_load), .irq(srcv[0]), .ref0_valid(srcv[1]),
        .ref1_valid(srcv[2]), .dbg_sys_fb_clk(srcv[3]), .dloop0_hold(srcv[4]),
        .dloop1_hold(srcv[5]), .dloop0_lock(srcv[6]), .dloop1_lock(srcv[7]),
        .aloop0_lock(srcv[8]), .aloop1_lock(srcv[9]), .aloop2_lock(srcv[10]),
        .rf_lock(srcv[11]), .device_ready_status_bit(srcv[12]), .dloop0_sel(srcv[13]),
        .dloop1_sel(srcv[14]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ref0_disqualify(ref0_dq), .ref1_disqualify(ref1_dq), .group_enable(group_en));

    gfm_board i_board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .brd_val(brd_val), .brd_en(brd_en), .pin_in(pin_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        int n;
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        failures++;
        conclude();
    end

    initial begin
        int n;
        int p;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        n = 0;
        // writes wait for the ready level on pin 3
        while (pin_out[2] !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk({7'h00, pin_out[2]}, 8'h01);
        chk({5'h00, pin_oe}, 8'h04);
        rchk(16'h0301, 8'h06);
        rchk(16'h0302, 8'h1A);
        rchk(16'h0303, 8'h03);
        rchk(16'h0300, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 25; i++) begin
            p = ROUTE[i][11:8] - 1;
            srcv = 15'h1000;
            wr(16'h0301 + 16'(p), {4'h1, ROUTE[i][7:4]});
            srcv = ~(15'h0001 << ROUTE[i][3:0]);
            repeat (2) @(negedge ref_clk);
            chk({7'h00, pin_out[p]}, 8'h00);
            chk({7'h00, pin_oe[p]}, 8'h01);
            srcv = 15'h0001 << ROUTE[i][3:0];
            repeat (2) @(negedge ref_clk);
            chk({7'h00, pin_out[p]}, 8'h01);
        end
        $display("test routing done");
        srcv = 15'h1000;
        brd_en = 3'h1;
        for (int k = 0; k < 2; k++) begin
            brd_val = 3'h0;
            wr(16'h0301, 8'h07 + 8'(k));
            repeat (4) @(negedge ref_clk);
            chk({7'h00, pin_oe[0]}, 8'h00);
            chk({6'h00, ref1_dq, ref0_dq}, 8'h00);
            brd_val = 3'h1;
            repeat (2) @(negedge ref_clk);
            chk({6'h00, ref1_dq, ref0_dq}, 8'h00);
            @(negedge ref_clk);
            chk({6'h00, ref1_dq, ref0_dq}, 8'h01 << k);
        end
        $display("test disqualify done");
        wr(16'h0301, 8'h06);
        wr(16'h0303, 8'h03);
        brd_en = 3'h2;
        for (int g = 0; g < 7; g++) begin
            brd_val = 3'h0;
            wr(16'h0302, 8'h09 + 8'(g));
            repeat (4) @(negedge ref_clk);
            chk({7'h00, pin_oe[1]}, 8'h00);
            chk({1'b0, group_en}, 8'h7F & ~(8'h01 << g));
            brd_val = 3'h2;
            repeat (4) @(negedge ref_clk);
            chk({1'b0, group_en}, 8'h7F);
        end
        $display("test groups done");
        nv_load = 1'b1;
        wr(16'h0301, 8'h15);
        nv_load = 1'b0;
        rchk(16'h0301, 8'h06);
        wr(16'h0300, 8'h1F);
        rchk(16'h0300, 8'h00);
        wr(16'h0301, 8'h15);
        rchk(16'h0301, 8'h15);
        $display("test nvload done");
        // a second reset in mid-run must bring every field back to its power-on code
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        rchk(16'h0301, 8'h06);
        rchk(16'h0302, 8'h1A);
        rchk(16'h0303, 8'h03);
        chk({5'h00, pin_oe}, 8'h04);
        $display("test second reset done");
        conclude();
    end
endmodule
